// ---- gpio_ports_with_ext_irq_sense_test.sv ----
// self-checking bench for the gpio port block
`default_nettype none
module gpio_ports_with_ext_irq_sense_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, rst_n = 0, bus_wr = 0, bus_rd = 0, mhi = 0, mlo = 0, nv = 0, b;
  logic [2:0] vf = 0;
  logic [7:0] bus_addr = 0, bus_wdata = 0;
  logic [47:0] asel = 0, adout = 0, app = 0, ext_val = 48'hffff_ffff_ffff;
  wire [7:0] bus_rdata;
  wire [47:0] pout, poe, pad;
  wire pull, la, lc, ld, irq;
  int err_total = 0, n_tests = 0;
  always #10 ref_clk = ~ref_clk;
  gpx_ports dut (.ref_clk(ref_clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .cpu_irq_mask_hi(mhi),
    .cpu_irq_mask_lo(mlo), .vec_fetch_a(vf[0]), .vec_fetch_c(vf[1]), .vec_fetch_d(vf[2]),
    .nv_pullup_sel(nv), .alt_sel(asel), .alt_dout(adout), .alt_pushpull(app),
    .port_a_in(pad[7:0]), .port_b_in(pad[15:8]), .port_c_in(pad[23:16]),
    .port_d_in(pad[31:24]), .port_e_in(pad[39:32]), .port_f_in(pad[47:40]),
    .port_a_out(pout[7:0]), .port_a_oe(poe[7:0]), .port_b_out(pout[15:8]),
    .port_b_oe(poe[15:8]), .port_c_out(pout[23:16]), .port_c_oe(poe[23:16]),
    .port_d_out(pout[31:24]), .port_d_oe(poe[31:24]), .port_e_out(pout[39:32]),
    .port_e_oe(poe[39:32]), .port_f_out(pout[47:40]), .port_f_oe(poe[47:40]),
    .gpio_e_pin5_pullup(pull), .ext_irq_line_a(la), .ext_irq_line_c(lc),
    .ext_irq_line_d(ld), .irq(irq));
  gpx_pad_model u_pads (.drv_out(pout), .drv_oe(poe), .ext_val(ext_val), .pad(pad));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    @(negedge ref_clk);
    chk(bus_rdata, exp);
  endtask
  task automatic pins(input logic v);
    @(posedge ref_clk);
    ext_val[0] <= v;
    ext_val[16] <= v;
    ext_val[24] <= v;
    cyc(4);
  endtask
  task automatic fetch;
    @(posedge ref_clk);
    vf <= 3'b111;
    @(posedge ref_clk);
    vf <= 3'b000;
    cyc(3);
  endtask
  task automatic t_reset;
    // data offsets sit every third byte and read the pins
    for (int a = 0; a < 17; a++)
      rd(a[7:0], (a % 3 == 0) ? ext_val[a / 3 * 8 +: 8] : 8'h00);
    rd(8'h49, 8'h00);
    rd(8'h20, 8'h00);
  endtask
  task automatic t_drive;
    wr(8'h00, 8'h5a);
    cyc(3);
    chk(poe[7:0], 8'h00);
    wr(8'h02, 8'hff);
    wr(8'h01, 8'hff);
    cyc(3);
    chk(pout[7:0], 8'h5a);
    chk(poe[7:0], 8'hff);
    wr(8'h02, 8'h00);
    ext_val[7:0] <= 8'h0f;
    cyc(3);
    chk(poe[7:0], 8'ha5);
    chk(pout[7:0] & poe[7:0], 8'h00);
    rd(8'h00, 8'h0a);
    wr(8'h01, 8'h0f);
    cyc(3);
    chk(poe[7:0], 8'h05);
    wr(8'h03, 8'h33);
    wr(8'h04, 8'hff);
    cyc(3);
    chk(pout[15:8], 8'h33);
    wr(8'h0f, 8'hff);
    wr(8'h10, 8'hff);
    cyc(3);
    chk(poe[47:40], 8'h0c);
    asel[8] <= 1'b1;
    app[8] <= 1'b1;
    cyc(3);
    chk({6'h00, pout[8], poe[8]}, 8'h01);
    asel[8] <= 1'b0;
  endtask
  task automatic t_irq;
    wr(8'h01, 8'h00);
    wr(8'h02, 8'h01);
    wr(8'h08, 8'h01);
    wr(8'h0b, 8'h01);
    ext_val[7:0] <= 8'hff;
    mhi <= 1'b1;
    mlo <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      wr(8'h49, {m[1:0], 1'b0, m[1:0], 3'b000});
      rd(8'h49, {m[1:0], 1'b0, m[1:0], 3'b000});
      pins(1'b0);
      chk({5'h00, la, lc, ld}, (m != 1) ? 8'h07 : 8'h02);
      fetch;
      chk({5'h00, la, lc, ld}, (m == 0) ? 8'h07 : 8'h02);
      pins(1'b1);
      chk({5'h00, la, lc, ld}, m[0] ? 8'h05 : 8'h00);
      fetch;
    end
    rd(8'h50, 8'h07);
    chk({7'h00, irq}, 8'h00);
    wr(8'h51, 8'h04);
    cyc(2);
    chk({7'h00, irq}, 8'h01);
    wr(8'h50, 8'h04);
    cyc(2);
    chk({7'h00, irq}, 8'h00);
    rd(8'h50, 8'h03);
  endtask
  task automatic t_ctl;
    mlo <= 1'b0;
    wr(8'h49, 8'h20);
    rd(8'h49, 8'hf8);
    cyc(2);
    b = pout[43];
    cyc(0);
    chk({6'h00, poe[43], pout[43] ^ b}, 8'h03);
    wr(8'h49, 8'h00);
    rd(8'h49, 8'hd8);
    cyc(2);
    b = pout[43];
    cyc(0);
    chk({6'h00, poe[43], pout[43] ^ b}, 8'h02);
  endtask
  task automatic t_pull;
    nv <= 1'b1;
    cyc(4);
    chk({7'h00, pull}, 8'h01);
    wr(8'h0d, 8'h20);
    wr(8'h0e, 8'h20);
    cyc(3);
    chk({7'h00, pull}, 8'h00);
  endtask
  task automatic print_verdict;
    if (err_total == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    // pin synchronisers hold zero until two edges after release
    cyc(3);
    t_reset;
    t_drive;
    t_irq;
    t_ctl;
    t_pull;
    print_verdict;
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_total++;
    print_verdict;
  end
endmodule // gpio_ports_with_ext_irq_sense_test
`default_nettype wire

// ---- gpx_pad_model.sv ----
// external circuitry on the 48 gpio pins
`default_nettype none
module gpx_pad_model (
  input wire logic [47:0] drv_out,
  input wire logic [47:0] drv_oe,
  input wire logic [47:0] ext_val,
  output logic [47:0] pad
);
  timeunit 1ns;
  timeprecision 1ns;
  // a driven pin shows the block's level, open-drain high lets the outside source win
  assign pad = (drv_oe & drv_out) | (~drv_oe & ext_val);
endmodule // gpx_pad_model
`default_nettype wire

// ---- gpx_ports.v ----
// six 8-bit gpio ports with external interrupt sensing and clock-out
// Overview of operation
// - port b: 0 floating input, 1 push-pull
// - data writes always update the output latch
// - data reads return synchronised pin levels
// - each direction bit: 0 input, 1 output
// - input option 1 enables pin interrupt on ports a, c and d
// - output option 0 open-drain, 1 push-pull on ports a, d and e; port c outputs are always push-pull
// - pins without option use direction alone, except port f pins 0, 1 and 4 to 7, which are open-drain
// - all port registers reset to zero
// - fixed consecutive byte map, one unused hole
// - port a sensitivity field bits 7:6
// - port d sensitivity field bits 4:3
// - sensitivity writable only at mask level three
// - clock-out enable drives clock onto pin
// - port e pin5 pull-up when option selected
// - request latch cleared by vector fetch
// - peripheral alternate function overrides pin setup
//
// Local design decision: the strobed register port.
`include "gpx_regs.vh"
`default_nettype none

module gpx_ports (
  input wire ref_clk,
  input wire rst_n,
  input wire [7:0] bus_addr,
  input wire [7:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  output reg [7:0] bus_rdata,
  input wire cpu_irq_mask_hi,
  input wire cpu_irq_mask_lo,
  input wire vec_fetch_a,
  input wire vec_fetch_c,
  input wire vec_fetch_d,
  input wire nv_pullup_sel,
  input wire [47:0] alt_sel,
  input wire [47:0] alt_dout,
  input wire [47:0] alt_pushpull,
  input wire [7:0] port_a_in,
  input wire [7:0] port_b_in,
  input wire [7:0] port_c_in,
  input wire [7:0] port_d_in,
  input wire [7:0] port_e_in,
  input wire [7:0] port_f_in,
  output reg [7:0] port_a_out,
  output reg [7:0] port_a_oe,
  output reg [7:0] port_b_out,
  output reg [7:0] port_b_oe,
  output reg [7:0] port_c_out,
  output reg [7:0] port_c_oe,
  output reg [7:0] port_d_out,
  output reg [7:0] port_d_oe,
  output reg [7:0] port_e_out,
  output reg [7:0] port_e_oe,
  output reg [7:0] port_f_out,
  output reg [7:0] port_f_oe,
  output reg gpio_e_pin5_pullup,
  output reg ext_irq_line_a,
  output reg ext_irq_line_c,
  output reg ext_irq_line_d,
  output reg irq
);

  // per-port offsets; ports without an option offset get port e's, which gpx_has_cfg masks out
  function [7:0] gpx_data_off;
    input [2:0] p;
    begin
      case (p)
        3'd0: gpx_data_off = `GPX_A_DATA_OFF;
        3'd1: gpx_data_off = `GPX_B_DATA_OFF;
        3'd2: gpx_data_off = `GPX_C_DATA_OFF;
        3'd3: gpx_data_off = `GPX_D_DATA_OFF;
        3'd4: gpx_data_off = `GPX_E_DATA_OFF;
        default: gpx_data_off = `GPX_F_DATA_OFF;
      endcase
    end
  endfunction

  function [7:0] gpx_dir_off;
    input [2:0] p;
    begin
      case (p)
        3'd0: gpx_dir_off = `GPX_A_DIR_OFF;
        3'd1: gpx_dir_off = `GPX_B_DIR_OFF;
        3'd2: gpx_dir_off = `GPX_C_DIR_OFF;
        3'd3: gpx_dir_off = `GPX_D_DIR_OFF;
        3'd4: gpx_dir_off = `GPX_E_DIR_OFF;
        default: gpx_dir_off = `GPX_F_DIR_OFF;
      endcase
    end
  endfunction

  function gpx_has_cfg;
    input [2:0] p;
    begin
      gpx_has_cfg = (p == 3'd0) || (p == 3'd2) || (p == 3'd3) || (p == 3'd4);
    end
  endfunction

  function [7:0] gpx_cfg_off;
    input [2:0] p;
    begin
      case (p)
        3'd0: gpx_cfg_off = `GPX_A_CFG_OFF;
        3'd2: gpx_cfg_off = `GPX_C_CFG_OFF;
        3'd3: gpx_cfg_off = `GPX_D_CFG_OFF;
        default: gpx_cfg_off = `GPX_E_CFG_OFF;
      endcase
    end
  endfunction

  // push-pull select per pin in output mode
  function [7:0] gpx_pp;
    input [2:0] p;
    input [7:0] cfg;
    begin
      case (p)
        3'd0: gpx_pp = cfg & `GPX_OPT_MASK_A;
        3'd1: gpx_pp = `GPX_PP_MASK_B;
        3'd2: gpx_pp = `GPX_PP_MASK_C;
        3'd3: gpx_pp = cfg & `GPX_OPT_MASK_D;
        3'd4: gpx_pp = cfg & `GPX_OPT_MASK_E;
        default: gpx_pp = `GPX_PP_MASK_F;
      endcase
    end
  endfunction

  // edge hit over enabled pins for the selected sensitivity
  function gpx_hit;
    input [1:0] mode;
    input [7:0] cur;
    input [7:0] prev;
    input [7:0] en;
    begin
      case (mode)
        `GPX_SENSE_RISE: gpx_hit = |(en & ~prev & cur);
        `GPX_SENSE_BOTH: gpx_hit = |(en & (prev ^ cur));
        default: gpx_hit = |(en & prev & ~cur);
      endcase
    end
  endfunction

  function gpx_low;
    input [1:0] mode;
    input [7:0] cur;
    input [7:0] en;
    begin
      gpx_low = (mode == `GPX_SENSE_FALL_LOW) && (|(en & ~cur));
    end
  endfunction

  // one loop index per process so that no variable has two drivers
  integer p;
  integer pd;
  integer pr;
  reg [7:0] data_reg [0:5];
  reg [7:0] dir_reg [0:5];
  reg [7:0] cfg_reg [0:5];
  reg [47:0] sync1_reg;
  reg [47:0] sync2_reg;
  reg [47:0] prev_reg;
  reg [1:0] sense_a_reg;
  reg [1:0] sense_d_reg;
  reg clkout_en_reg;
  reg clk_div_reg;
  reg [2:0] req_latch_reg;
  reg [2:0] irq_stat_reg;
  reg [2:0] irq_mask_reg;
  reg [1:0] pullup_sync_reg;

  wire [47:0] pin_raw = {port_f_in, port_e_in, port_d_in, port_c_in, port_b_in, port_a_in};
  wire wr_ctl = bus_wr && (bus_addr == `GPX_CTL_OFF);
  wire sense_wr_ok = wr_ctl && cpu_irq_mask_hi && cpu_irq_mask_lo;
  wire [1:0] wr_sense_a = bus_wdata[`GPX_SENSE_A_HI:`GPX_SENSE_A_LO];
  wire [1:0] wr_sense_d = bus_wdata[`GPX_SENSE_D_HI:`GPX_SENSE_D_LO];
  // changing a field drops a stale pending request
  wire sense_a_chg = sense_wr_ok && (wr_sense_a != sense_a_reg);
  wire sense_d_chg = sense_wr_ok && (wr_sense_d != sense_d_reg);

  // interrupt-capable pins: input mode with option set
  wire [7:0] en_a = ~dir_reg[0] & cfg_reg[0];
  wire [7:0] en_c = ~dir_reg[2] & cfg_reg[2];
  wire [7:0] en_d = ~dir_reg[3] & cfg_reg[3];

  // port c has no sensitivity field here; it stays in falling-plus-low mode
  wire [2:0] evt;
  assign evt[`GPX_IRQ_A_BIT] = gpx_hit(sense_a_reg, sync2_reg[7:0], prev_reg[7:0], en_a);
  assign evt[`GPX_IRQ_C_BIT] = gpx_hit(`GPX_SENSE_FALL_LOW, sync2_reg[23:16],
    prev_reg[23:16], en_c);
  assign evt[`GPX_IRQ_D_BIT] = gpx_hit(sense_d_reg, sync2_reg[31:24], prev_reg[31:24], en_d);
  wire [2:0] lvl;
  assign lvl[`GPX_IRQ_A_BIT] = gpx_low(sense_a_reg, sync2_reg[7:0], en_a);
  assign lvl[`GPX_IRQ_C_BIT] = gpx_low(`GPX_SENSE_FALL_LOW, sync2_reg[23:16], en_c);
  assign lvl[`GPX_IRQ_D_BIT] = gpx_low(sense_d_reg, sync2_reg[31:24], en_d);

  wire [2:0] latch_clr = {vec_fetch_d | sense_d_chg, vec_fetch_c, vec_fetch_a | sense_a_chg};
  // set wins over the vector-fetch clear so an edge in that cycle is kept
  wire [2:0] req_latch_next = (req_latch_reg & ~latch_clr) | evt;
  wire [2:0] stat_clr = (bus_wr && (bus_addr == `GPX_IRQ_STAT_OFF)) ? bus_wdata[2:0] : 3'b000;
  wire [2:0] irq_stat_next = (irq_stat_reg & ~stat_clr) | evt;
  wire [2:0] irq_mask_next = (bus_wr && (bus_addr == `GPX_IRQ_MASK_OFF)) ?
    bus_wdata[2:0] : irq_mask_reg;

  // pin drive, alternate functions over the port setup, clock-out last so it takes priority on pin 43
  reg [47:0] drv_out_next;
  reg [47:0] drv_oe_next;
  reg [7:0] pp_v;
  always @* begin
    drv_out_next = 48'h0000_0000_0000;
    drv_oe_next = 48'h0000_0000_0000;
    pp_v = 8'h00;
    for (pd = 0; pd < `GPX_NUM_PORTS; pd = pd + 1) begin
      pp_v = gpx_pp(pd[2:0], cfg_reg[pd]);
      drv_oe_next[pd*8 +: 8] = dir_reg[pd] & (pp_v | ~data_reg[pd]);
      drv_out_next[pd*8 +: 8] = data_reg[pd] & pp_v;
    end
    drv_oe_next = (drv_oe_next & ~alt_sel) | (alt_sel & (alt_pushpull | ~alt_dout));
    drv_out_next = (drv_out_next & ~alt_sel) | (alt_sel & alt_dout & alt_pushpull);
    if (clkout_en_reg) begin
      drv_oe_next[`GPX_CLKOUT_PIN] = 1'b1;
      drv_out_next[`GPX_CLKOUT_PIN] = clk_div_reg;
    end
  end

  // pull-up on pin5 only when floating input or open drain
  wire e5_dir = dir_reg[4][`GPX_PULLUP_BIT];
  wire e5_cfg = cfg_reg[4][`GPX_PULLUP_BIT];
  wire pullup_next = pullup_sync_reg[1] && (!e5_dir || !e5_cfg);

  // read mux, unmapped addresses read zero
  reg [7:0] rd_next;
  always @* begin
    rd_next = 8'h00;
    if (bus_addr == `GPX_CTL_OFF) begin
      rd_next = {sense_a_reg, clkout_en_reg, sense_d_reg, 3'b000};
    end else if (bus_addr == `GPX_IRQ_STAT_OFF) begin
      rd_next = {5'b00000, irq_stat_reg};
    end else if (bus_addr == `GPX_IRQ_MASK_OFF) begin
      rd_next = {5'b00000, irq_mask_reg};
    end else begin
      for (pr = 0; pr < `GPX_NUM_PORTS; pr = pr + 1) begin
        if (bus_addr == gpx_data_off(pr[2:0])) begin
          rd_next = sync2_reg[pr*8 +: 8];
        end else if (bus_addr == gpx_dir_off(pr[2:0])) begin
          rd_next = dir_reg[pr];
        end else if (gpx_has_cfg(pr[2:0]) && (bus_addr == gpx_cfg_off(pr[2:0]))) begin
          rd_next = cfg_reg[pr];
        end
      end
    end
  end

  // port registers
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (p = 0; p < `GPX_NUM_PORTS; p = p + 1) begin
        data_reg[p] <= `GPX_RST_VAL;
        dir_reg[p] <= `GPX_RST_VAL;
        cfg_reg[p] <= `GPX_RST_VAL;
      end
    end else if (bus_wr) begin
      for (p = 0; p < `GPX_NUM_PORTS; p = p + 1) begin
        if (bus_addr == gpx_data_off(p[2:0])) begin
          data_reg[p] <= bus_wdata;
        end else if (bus_addr == gpx_dir_off(p[2:0])) begin
          dir_reg[p] <= bus_wdata;
        end else if (gpx_has_cfg(p[2:0]) && (bus_addr == gpx_cfg_off(p[2:0]))) begin
          cfg_reg[p] <= bus_wdata;
        end
      end
    end
  end

  // synchronisers, control, interrupt state and registered outputs
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 48'h0000_0000_0000;
      sync2_reg <= 48'h0000_0000_0000;
      prev_reg <= 48'h0000_0000_0000;
      pullup_sync_reg <= 2'b00;
      sense_a_reg <= `GPX_SENSE_FALL_LOW;
      sense_d_reg <= `GPX_SENSE_FALL_LOW;
      clkout_en_reg <= 1'b0;
      clk_div_reg <= 1'b0;
      req_latch_reg <= 3'b000;
      irq_stat_reg <= 3'b000;
      irq_mask_reg <= 3'b000;
      bus_rdata <= 8'h00;
      {port_f_out, port_e_out, port_d_out, port_c_out, port_b_out, port_a_out} <=
        48'h0000_0000_0000;
      {port_f_oe, port_e_oe, port_d_oe, port_c_oe, port_b_oe, port_a_oe} <=
        48'h0000_0000_0000;
      gpio_e_pin5_pullup <= 1'b0;
      ext_irq_line_a <= 1'b0;
      ext_irq_line_c <= 1'b0;
      ext_irq_line_d <= 1'b0;
      irq <= 1'b0;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
      pullup_sync_reg <= {pullup_sync_reg[0], nv_pullup_sel};
      if (sense_wr_ok) begin
        sense_a_reg <= wr_sense_a;
        sense_d_reg <= wr_sense_d;
      end
      if (wr_ctl) begin
        clkout_en_reg <= bus_wdata[`GPX_CLKOUT_BIT];
      end
      // a flop cannot pass the clock itself, so the pin carries half the rate
      clk_div_reg <= clkout_en_reg ? ~clk_div_reg : 1'b0;
      req_latch_reg <= req_latch_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      bus_rdata <= bus_rd ? rd_next : 8'h00;
      {port_f_out, port_e_out, port_d_out, port_c_out, port_b_out, port_a_out} <= drv_out_next;
      {port_f_oe, port_e_oe, port_d_oe, port_c_oe, port_b_oe, port_a_oe} <= drv_oe_next;
      gpio_e_pin5_pullup <= pullup_next;
      ext_irq_line_a <= req_latch_next[`GPX_IRQ_A_BIT] | lvl[`GPX_IRQ_A_BIT];
      ext_irq_line_c <= req_latch_next[`GPX_IRQ_C_BIT] | lvl[`GPX_IRQ_C_BIT];
      ext_irq_line_d <= req_latch_next[`GPX_IRQ_D_BIT] | lvl[`GPX_IRQ_D_BIT];
      irq <= |(irq_stat_next & irq_mask_next);
    end
  end

endmodule // gpx_ports

`default_nettype wire

// ---- gpx_ports_properties.sv ----
// concurrent checks on the gpio port block
`default_nettype none
module gpx_ports_properties (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire logic cpu_irq_mask_hi,
  input wire logic cpu_irq_mask_lo,
  input wire logic vec_fetch_a,
  input wire logic [47:0] alt_sel,
  input wire logic [7:0] port_a_in,
  input wire logic [7:0] port_b_in,
  input wire logic [7:0] port_b_oe,
  input wire logic [7:0] port_f_out,
  input wire logic [7:0] port_f_oe,
  input wire logic ext_irq_line_a,
  input wire logic irq
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  a_rdata_idle: assert property (
    !$past(bus_rd) |-> bus_rdata == 8'h00) else $error("read data not idle");
  a_hole_reads_zero: assert property (
    bus_rd && bus_addr == 8'h05 |=> bus_rdata == 8'h00) else $error("hole read nonzero");
  // reset history guard keeps the sync flops' reset value out of the comparison
  a_pin_read_back: assert property (
    bus_rd && bus_addr == 8'h03 && $past(rst_n, 3) && $stable(port_b_in) &&
    $past(port_b_in, 2) == port_b_in && $past(port_b_in, 3) == port_b_in
    |=> bus_rdata == $past(port_b_in)) else $error("data read not pin level");
  a_dir_b_drive: assert property (
    bus_wr && bus_addr == 8'h04 ##1 (!(bus_wr && bus_addr == 8'h04) && alt_sel[15:8] == 8'h00) [*2]
    |=> port_b_oe == $past(bus_wdata, 3)) else $error("port b enable wrong");
  a_edge_cause: assert property (
    $rose(ext_irq_line_a) |-> $past(port_a_in, 2) != $past(port_a_in, 3) ||
    $past(port_a_in, 3) != $past(port_a_in, 4) || $past(port_a_in, 2) != 8'hff ||
    $past(port_a_in, 3) != 8'hff) else $error("request without pin event");
  a_fetch_clears: assert property (
    vec_fetch_a && !bus_wr && port_a_in == 8'hff && $past(port_a_in) == 8'hff &&
    $past(port_a_in, 2) == 8'hff && $past(port_a_in, 3) == 8'hff
    |-> ##2 !ext_irq_line_a) else $error("fetch left request set");
  a_clock_out: assert property (
    bus_wr && bus_addr == 8'h49 && bus_wdata[5] ##1 !(bus_wr && bus_addr == 8'h49) [*3]
    |=> port_f_oe[3] && port_f_out[3] != $past(port_f_out[3]))
    else $error("clock-out pin idle");
  a_sense_read: assert property (
    bus_wr && bus_addr == 8'h49 && cpu_irq_mask_hi && cpu_irq_mask_lo ##2
    bus_rd && bus_addr == 8'h49 |=> bus_rdata == ($past(bus_wdata, 3) & 8'hf8))
    else $error("control read back wrong");
  c_irq_line: cover property ($rose(ext_irq_line_a));
  c_irq_out: cover property ($rose(irq));
  c_clock_out: cover property (bus_wr && bus_addr == 8'h49 && bus_wdata[5]);
endmodule // gpx_ports_properties
bind gpx_ports gpx_ports_properties u_props (.ref_clk(ref_clk), .rst_n(rst_n),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_rdata(bus_rdata), .cpu_irq_mask_hi(cpu_irq_mask_hi), .cpu_irq_mask_lo(cpu_irq_mask_lo),
  .vec_fetch_a(vec_fetch_a), .alt_sel(alt_sel), .port_a_in(port_a_in), .port_b_in(port_b_in),
  .port_b_oe(port_b_oe), .port_f_out(port_f_out), .port_f_oe(port_f_oe),
  .ext_irq_line_a(ext_irq_line_a), .irq(irq));
`default_nettype wire

// ---- gpx_regs.vh ----
// register offsets, field positions, reset values and pin masks of the gpio port block
`ifndef GPX_REGS_VH
`define GPX_REGS_VH

`define GPX_NUM_PORTS 6
`define GPX_RST_VAL 8'h00

// port register byte offsets
`define GPX_A_DATA_OFF 8'h00
`define GPX_A_DIR_OFF 8'h01
`define GPX_A_CFG_OFF 8'h02
`define GPX_B_DATA_OFF 8'h03
`define GPX_B_DIR_OFF 8'h04
`define GPX_UNUSED_OFF 8'h05
`define GPX_C_DATA_OFF 8'h06
`define GPX_C_DIR_OFF 8'h07
`define GPX_C_CFG_OFF 8'h08
`define GPX_D_DATA_OFF 8'h09
`define GPX_D_DIR_OFF 8'h0a
`define GPX_D_CFG_OFF 8'h0b
`define GPX_E_DATA_OFF 8'h0c
`define GPX_E_DIR_OFF 8'h0d
`define GPX_E_CFG_OFF 8'h0e
`define GPX_F_DATA_OFF 8'h0f
`define GPX_F_DIR_OFF 8'h10

// sensitivity and clock-out control, plus interrupt status and mask
`define GPX_CTL_OFF 8'h49
`define GPX_IRQ_STAT_OFF 8'h50
`define GPX_IRQ_MASK_OFF 8'h51

// control register fields
`define GPX_SENSE_A_HI 7
`define GPX_SENSE_A_LO 6
`define GPX_CLKOUT_BIT 5
`define GPX_SENSE_D_HI 4
`define GPX_SENSE_D_LO 3

// sensitivity encodings
`define GPX_SENSE_FALL_LOW 2'b00
`define GPX_SENSE_RISE 2'b01
`define GPX_SENSE_FALL 2'b10
`define GPX_SENSE_BOTH 2'b11

// interrupt status bits
`define GPX_IRQ_A_BIT 0
`define GPX_IRQ_C_BIT 1
`define GPX_IRQ_D_BIT 2

// pins whose output drive follows the option bit, and pins fixed push-pull
`define GPX_OPT_MASK_A 8'hff
`define GPX_OPT_MASK_D 8'hff
`define GPX_OPT_MASK_E 8'hff
`define GPX_PP_MASK_B 8'hff
`define GPX_PP_MASK_C 8'hff
`define GPX_PP_MASK_F 8'h0c

// clock-out alternate pin: port f pin 3, flat index 43
`define GPX_CLKOUT_PIN 43
// pull-up capable pin: port e pin 5
`define GPX_PULLUP_BIT 5

`endif
